// ### logic/dtc_pkg.sv
// package: register map, field layout and types of the dual timer/counter
package dtc_pkg;

  // ****************************************************************
  // register byte offsets
  // ****************************************************************
  localparam logic [7:0] DTC_OFS_MODE = 8'h00;
  localparam logic [7:0] DTC_OFS_CTRL = 8'h04;
  localparam logic [7:0] DTC_OFS_CNT0 = 8'h08;
  localparam logic [7:0] DTC_OFS_CNT1 = 8'h0c;
  localparam logic [7:0] DTC_OFS_STS  = 8'h10;
  localparam logic [7:0] DTC_OFS_CLR  = 8'h14;
  localparam logic [7:0] DTC_OFS_IEN  = 8'h18;

  // ****************************************************************
  // field positions
  // ****************************************************************
  localparam int DTC_T0_FLD   = 0;
  localparam int DTC_T1_FLD   = 4;
  localparam int DTC_RUN0_BIT = 4;
  localparam int DTC_OVF0_BIT = 5;
  localparam int DTC_RUN1_BIT = 6;
  localparam int DTC_OVF1_BIT = 7;

  // ****************************************************************
  // reset values and count limits
  // ****************************************************************
  localparam logic [7:0]  DTC_MODE_RST  = 8'h00;
  localparam logic [1:0]  DTC_BIT2_RST  = 2'h0;
  localparam logic [15:0] DTC_CNT_RST   = 16'h0000;
  localparam logic [4:0]  DTC_PRESC_MAX = 5'h1f;
  localparam logic [7:0]  DTC_BYTE_MAX  = 8'hff;
  localparam logic [15:0] DTC_CNT_MAX   = 16'hffff;

  // ****************************************************************
  // types
  // ****************************************************************
  typedef enum logic [1:0] {
    DTC_M13,
    DTC_M16,
    DTC_RELOAD,
    DTC_SPLIT
  } dtc_mode_e;

  // one nibble of timer_mode_select: gate at bit 3, source at bit 2
  typedef struct packed {
    logic      gate;
    logic      csel;
    dtc_mode_e mode;
  } dtc_tmode_s;

  typedef struct packed {
    logic [7:0] hi;
    logic [7:0] lo;
  } dtc_cnt_s;

  typedef struct packed {
    logic       valid;
    logic [7:0] addr;
  } dtc_wph_s;

endpackage

// ### logic/dtc_edge_sync.sv
// module: two-flop synchroniser and falling-edge detector per count pin
`timescale 1ns/1ps
`default_nettype none
module dtc_edge_sync #(
  parameter int W = 2
) (
  input  wire logic         sys_clk,
  input  wire logic         sys_rst,
  input  wire logic         clk_en,
  input  wire logic [W-1:0] pin_in,
  output var  logic [W-1:0] fall_out
);
  if (W < 1) begin : g_chk
    $error("dtc_edge_sync: W must be at least 1");
  end

  for (genvar i = 0; i < W; i++) begin : g_bit
    logic meta_r, sync_r, prev_r;
    logic meta_nxt, sync_nxt, prev_nxt;

    always_comb begin
      meta_nxt = pin_in[i];
      sync_nxt = meta_r;
      prev_nxt = sync_r;
    end

    always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
        meta_r <= 1'b0;
        sync_r <= 1'b0;
        prev_r <= 1'b0;
      end else if (clk_en) begin
        meta_r <= meta_nxt;
        sync_r <= sync_nxt;
        prev_r <= prev_nxt;
      end
    end

    // edge seen only after both flops, never on the first one
    assign fall_out[i] = prev_r && !sync_r;
  end
endmodule
`default_nettype wire

// ### logic/dtc_top.sv
// module: dual timer/counter with shared mode register, ahb-lite slave
`timescale 1ns/1ps
`default_nettype none
// ****************************************************************
// ****************************************************************
module dtc_top #(
  parameter int ADDR_W = 8
) (
  input  wire logic              sys_clk,
  input  wire logic              sys_rst,
  input  wire logic              clk_en,
  input  wire logic              hsel,
  input  wire logic [ADDR_W-1:0] haddr,
  input  wire logic [1:0]        htrans,
  input  wire logic              hwrite,
  input  wire logic [2:0]        hsize,
  input  wire logic [31:0]       hwdata,
  input  wire logic              hready,
  output logic      [31:0]       hrdata,
  output logic                   hreadyout,
  output logic                   hresp,
  input  wire logic [1:0]        external_qualify_pin,
  input  wire logic [1:0]        count_pin,
  input  wire logic [1:0]        vector_ack,
  output logic      [1:0]        overflow_flag,
  output logic                   irq
);
  import dtc_pkg::*;

  if (ADDR_W < 8 || ADDR_W > 32) begin : g_chk
    $error("dtc_top: ADDR_W must lie in 8..32");
  end

  // ****************************************************************
  // state
  // ****************************************************************
  logic [7:0]  mode_r,  mode_nxt;
  logic [1:0]  run_r,   run_nxt;
  logic [1:0]  tf_r,    tf_nxt;
  logic [1:0]  sts_r,   sts_nxt;
  logic [1:0]  ien_r,   ien_nxt;
  logic        irq_r,   irq_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  logic        rdy_r;
  dtc_wph_s    wph_r,   wph_nxt;
  dtc_cnt_s    cnt0_r,  cnt0_nxt;
  dtc_cnt_s    cnt1_r,  cnt1_nxt;

  dtc_tmode_s  t0m, t1m;
  logic [1:0]  cnt_fall;
  logic [1:0]  ovf_evt;
  logic        t1_ov;
  logic        inc0, inc1, acc;
  logic        wr_mode, wr_ctrl, wr_cnt0, wr_cnt1, wr_clr, wr_ien;
  logic [7:0]  ctrl_view;

  assign t0m = dtc_tmode_s'(mode_r[DTC_T0_FLD +: 4]);
  assign t1m = dtc_tmode_s'(mode_r[DTC_T1_FLD +: 4]);

  dtc_edge_sync #(
    .W (2)
  ) u_sync (
    .sys_clk  (sys_clk),
    .sys_rst  (sys_rst),
    .clk_en   (clk_en),
    .pin_in   (count_pin),
    .fall_out (cnt_fall)
  );

  // ****************************************************************
  // count enables
  // ****************************************************************
  // internal source counts on every enabled clock; pin source on edges
  assign inc0 = run_r[0] && (!t0m.gate || external_qualify_pin[0])
                && (!t0m.csel || cnt_fall[0]);
  assign inc1 = run_r[1] && (!t1m.gate || external_qualify_pin[1])
                && (!t1m.csel || cnt_fall[1]);

  function automatic logic [16:0] dtc_step(input dtc_mode_e m,
                                           input dtc_cnt_s  c,
                                           input logic      inc);
    dtc_cnt_s n;
    logic     ov;
    n  = c;
    ov = 1'b0;
    if (inc) begin
      unique case (m)
        DTC_M13: begin
          // low five bits prescale, upper three bits of low byte stay
          if (c.lo[4:0] == DTC_PRESC_MAX) begin
            n.lo[4:0] = 5'h00;
            n.hi      = c.hi + 8'h01;
            ov        = (c.hi == DTC_BYTE_MAX);
          end else begin
            n.lo[4:0] = c.lo[4:0] + 5'h01;
          end
        end
        DTC_M16: begin
          n  = dtc_cnt_s'(16'(c + 16'h0001));
          ov = (c == DTC_CNT_MAX);
        end
        DTC_RELOAD: begin
          if (c.lo == DTC_BYTE_MAX) begin
            n.lo = c.hi;
            ov   = 1'b1;
          end else begin
            n.lo = c.lo + 8'h01;
          end
        end
        DTC_SPLIT: n = c;
      endcase
    end
    return {ov, n};
  endfunction

  // ****************************************************************
  // timer group
  // ****************************************************************
  always_comb begin
    cnt0_nxt = cnt0_r;
    cnt1_nxt = cnt1_r;
    ovf_evt  = 2'b00;
    t1_ov    = 1'b0;
    if (t0m.mode == DTC_SPLIT) begin
      if (inc0) begin
        cnt0_nxt.lo = cnt0_r.lo + 8'h01;
        ovf_evt[0]  = (cnt0_r.lo == DTC_BYTE_MAX);
      end
      // high byte borrows timer 1 run bit and its overflow flag
      if (run_r[1]) begin
        cnt0_nxt.hi = cnt0_r.hi + 8'h01;
        ovf_evt[1]  = (cnt0_r.hi == DTC_BYTE_MAX);
      end
    end else begin
      {ovf_evt[0], cnt0_nxt} = dtc_step(t0m.mode, cnt0_r, inc0);
    end
    if (t1m.mode != DTC_SPLIT) begin
      {t1_ov, cnt1_nxt} = dtc_step(t1m.mode, cnt1_r, inc1);
      if (t0m.mode != DTC_SPLIT) begin
        ovf_evt[1] = t1_ov;
      end
    end
    // a software write wins over the count of the same cycle
    if (wr_cnt0) begin
      cnt0_nxt = dtc_cnt_s'(hwdata[15:0]);
    end
    if (wr_cnt1) begin
      cnt1_nxt = dtc_cnt_s'(hwdata[15:0]);
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      cnt0_r <= DTC_CNT_RST;
      cnt1_r <= DTC_CNT_RST;
    end else if (clk_en) begin
      cnt0_r <= cnt0_nxt;
      cnt1_r <= cnt1_nxt;
    end
  end

  // ****************************************************************
  // bus and register group
  // ****************************************************************
  assign acc     = hsel && htrans[1] && hready;
  assign wr_mode = wph_r.valid && wph_r.addr == DTC_OFS_MODE;
  assign wr_ctrl = wph_r.valid && wph_r.addr == DTC_OFS_CTRL;
  assign wr_cnt0 = wph_r.valid && wph_r.addr == DTC_OFS_CNT0;
  assign wr_cnt1 = wph_r.valid && wph_r.addr == DTC_OFS_CNT1;
  assign wr_clr  = wph_r.valid && wph_r.addr == DTC_OFS_CLR;
  assign wr_ien  = wph_r.valid && wph_r.addr == DTC_OFS_IEN;

  always_comb begin
    ctrl_view               = 8'h00;
    ctrl_view[DTC_RUN0_BIT] = run_r[0];
    ctrl_view[DTC_OVF0_BIT] = tf_r[0];
    ctrl_view[DTC_RUN1_BIT] = run_r[1];
    ctrl_view[DTC_OVF1_BIT] = tf_r[1];
  end

  always_comb begin
    // writing the mode alone never touches the run bits
    mode_nxt = wr_mode ? hwdata[7:0] : mode_r;
    run_nxt  = run_r;
    if (wr_ctrl) begin
      run_nxt = {hwdata[DTC_RUN1_BIT], hwdata[DTC_RUN0_BIT]};
    end
    // set wins over the vectoring clear
    tf_nxt  = (tf_r & ~vector_ack) | ovf_evt;
    sts_nxt = (sts_r & ~(wr_clr ? hwdata[1:0] : 2'b00)) | ovf_evt;
    ien_nxt = wr_ien ? hwdata[1:0] : ien_r;
    irq_nxt = |(sts_r & ien_r);
    wph_nxt = '{valid: acc && hwrite, addr: haddr[7:0]};
    rdata_nxt = rdata_r;
    if (acc && !hwrite) begin
      case (haddr[7:0])
        DTC_OFS_MODE: rdata_nxt = {24'h000000, mode_r};
        DTC_OFS_CTRL: rdata_nxt = {24'h000000, ctrl_view};
        DTC_OFS_CNT0: rdata_nxt = {16'h0000, cnt0_r};
        DTC_OFS_CNT1: rdata_nxt = {16'h0000, cnt1_r};
        DTC_OFS_STS:  rdata_nxt = {30'h0, sts_r};
        DTC_OFS_IEN:  rdata_nxt = {30'h0, ien_r};
        default:      rdata_nxt = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      mode_r  <= DTC_MODE_RST;
      run_r   <= DTC_BIT2_RST;
      tf_r    <= DTC_BIT2_RST;
      sts_r   <= DTC_BIT2_RST;
      ien_r   <= DTC_BIT2_RST;
      irq_r   <= 1'b0;
      rdata_r <= 32'h00000000;
      rdy_r   <= 1'b0;
      wph_r   <= '0;
    end else if (clk_en) begin
      mode_r  <= mode_nxt;
      run_r   <= run_nxt;
      tf_r    <= tf_nxt;
      sts_r   <= sts_nxt;
      ien_r   <= ien_nxt;
      irq_r   <= irq_nxt;
      rdata_r <= rdata_nxt;
      rdy_r   <= 1'b1;
      wph_r   <= wph_nxt;
    end
  end

  // zero wait states: every transfer completes in its first data cycle
  assign hrdata        = rdata_r;
  assign hreadyout     = rdy_r;
  assign hresp         = 1'b0;
  assign overflow_flag = tf_r;
  assign irq           = irq_r;

  // ****************************************************************
  // assertions
  // ****************************************************************
  default clocking dtc_cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);

  sequence s_pin_fall;
    (clk_en && count_pin[0]) ##1 (clk_en && !count_pin[0]) ##1 clk_en;
  endsequence

  sequence s_ovf_unmasked;
    (clk_en && ovf_evt[0] && ien_r[0] && !wr_ien) ##1 clk_en;
  endsequence

  a_gate_holds: assert property (
    clk_en && !wr_cnt0 && run_r[0] && t0m.gate && !external_qualify_pin[0]
    |=> cnt0_r.lo == $past(cnt0_r.lo))
    else $error("timer 0 counted with qualify pin low");

  a_soft_stop: assert property (
    clk_en && !wr_cnt0 && !run_r[0] |=> $stable(cnt0_r.lo))
    else $error("timer 0 counted with run bit clear");

  a_timer_step: assert property (
    clk_en && !wr_cnt0 && run_r[0] && !t0m.gate && !t0m.csel
    && t0m.mode == DTC_M16
    |=> cnt0_r == 16'($past(cnt0_r) + 16'h0001))
    else $error("16-bit timer did not step by one");

  a_pin_sync: assert property (
    s_pin_fall |=> cnt_fall[0])
    else $error("falling count pin edge not detected in time");

  a_prescale: assert property (
    clk_en && !wr_cnt0 && inc0 && t0m.mode == DTC_M13
    && cnt0_r.lo[4:0] == 5'h1f
    |=> cnt0_r.hi == 8'($past(cnt0_r.hi) + 8'h01)
        && cnt0_r.lo[4:0] == 5'h00)
    else $error("prescaler carry did not reach high byte");

  a_reload_low: assert property (
    clk_en && !wr_cnt0 && inc0 && t0m.mode == DTC_RELOAD
    && cnt0_r.lo == 8'hff
    |=> cnt0_r.lo == $past(cnt0_r.hi) && overflow_flag[0])
    else $error("auto-reload or overflow flag missing");

  a_split_high: assert property (
    clk_en && !wr_cnt0 && t0m.mode == DTC_SPLIT && run_r[1]
    |=> cnt0_r.hi == 8'($past(cnt0_r.hi) + 8'h01))
    else $error("split high byte did not follow timer 1 run");

  a_t1_frozen: assert property (
    clk_en && !wr_cnt1 && t1m.mode == DTC_SPLIT |=> $stable(cnt1_r))
    else $error("timer 1 moved in split mode");

  a_flag_clear: assert property (
    clk_en && vector_ack[0] && !ovf_evt[0] |=> !overflow_flag[0])
    else $error("overflow flag not cleared on vectoring");

  a_mode_layout: assert property (
    clk_en && wr_mode
    |=> t0m.gate == $past(hwdata[3]) && t1m.gate == $past(hwdata[7])
        && t0m.csel == $past(hwdata[2]) && t1m.csel == $past(hwdata[6]))
    else $error("mode register fields misplaced");

  a_irq_raise: assert property (
    s_ovf_unmasked |=> irq)
    else $error("enabled overflow did not raise interrupt");

endmodule
`default_nettype wire

// ### testbench/dtc_pin_model.sv
// model: gate and count pins seen by the dual timer/counter
`timescale 1ns/1ps
`default_nettype none
module dtc_pin_model (
  input  wire logic       sys_clk,
  output var  logic [1:0] external_qualify_pin,
  output var  logic [1:0] count_pin
);
  initial begin
    external_qualify_pin = 2'h0;
    count_pin            = 2'h3;
  end

  // gate pin high for exactly n sampling edges
  task automatic gate_high(input int idx, input int n);
    @(posedge sys_clk);
    external_qualify_pin[idx] <= 1'b1;
    repeat (n) @(posedge sys_clk);
    external_qualify_pin[idx] <= 1'b0;
  endtask

  // slow edges: the pin synchroniser must never miss a fall
  task automatic count_edges(input int idx, input int n);
    repeat (n) begin
      @(posedge sys_clk);
      count_pin[idx] <= 1'b0;
      repeat (2) @(posedge sys_clk);
      count_pin[idx] <= 1'b1;
      repeat (2) @(posedge sys_clk);
    end
  endtask
endmodule
`default_nettype wire

// ### testbench/dtc_tb_top.sv
// testbench: register-level tests of the dual timer/counter
`timescale 1ns/1ps
`default_nettype none
module dtc_tb_top;
  import dtc_pkg::*;
  logic        sys_clk;
  logic        sys_rst    = 1'b1;
  logic        hsel       = 1'b0;
  logic        hwrite     = 1'b0;
  logic [7:0]  haddr      = 8'h00;
  logic [1:0]  htrans     = 2'h0;
  logic [31:0] hwdata     = 32'h0;
  logic [1:0]  vector_ack = 2'h0;
  logic [31:0] hrdata;
  logic [31:0] rd_val;
  logic        hreadyout;
  logic        irq;
  logic        hresp;
  logic        clk_en     = 1'b1;
  logic [1:0]  qual_pin;
  logic [1:0]  cnt_pin;
  logic [1:0]  ovf;
  int          err_count  = 0;
  int          tests_run  = 0;

  dtc_top #(.ADDR_W(8)) dtc_top_inst (
    .sys_clk(sys_clk), .sys_rst(sys_rst), .clk_en(clk_en), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
    .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .external_qualify_pin(qual_pin),
    .count_pin(cnt_pin), .vector_ack(vector_ack), .overflow_flag(ovf),
    .irq(irq)
  );

  dtc_pin_model dtc_pin_model_inst (
    .sys_clk(sys_clk), .external_qualify_pin(qual_pin), .count_pin(cnt_pin)
  );

  initial begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end

  // ****************************************************************
  // bus and check tasks
  // ****************************************************************
  task automatic end_sim();
    $display("mismatches %0d, checks %0d", err_count, tests_run);
    if (err_count == 0 && tests_run > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // single word transfer; waits on hready in both phases
  task automatic xfer(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
    @(posedge sys_clk);
    hsel   <= 1'b1;
    haddr  <= a;
    hwrite <= w;
    htrans <= 2'h2;
    do @(posedge sys_clk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge sys_clk); while (hreadyout !== 1'b1);
    rd_val = hrdata;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    xfer(1'b0, a, 32'h0);
    chk(rd_val, exp);
  endtask

  // timer 0 runs only while its gate pin is held high for n edges
  task automatic gated(input logic [7:0] m, input logic [15:0] pre,
                       input int n, input logic [15:0] exp);
    wr(DTC_OFS_MODE, {24'h0, m});
    wr(DTC_OFS_CNT0, {16'h0, pre});
    wr(DTC_OFS_CTRL, 32'h10);
    dtc_pin_model_inst.gate_high(0, n);
    wr(DTC_OFS_CTRL, 32'h0);
    rd_chk(DTC_OFS_CNT0, {16'h0, exp});
  endtask

  initial begin
    repeat (5000) @(posedge sys_clk);
    err_count++;
    end_sim();
  end

  // ****************************************************************
  // test sequence
  // ****************************************************************
  initial begin
    repeat (12) @(posedge sys_clk);
    sys_rst <= 1'b0;
    repeat (2) @(posedge sys_clk);
    rd_chk(DTC_OFS_MODE, {24'h0, DTC_MODE_RST});
    rd_chk(DTC_OFS_CNT0, 32'h0);
    rd_chk(8'h1c, 32'h0);
    chk({31'h0, hresp}, 32'h0);
    wr(DTC_OFS_MODE, 32'h69);
    rd_chk(DTC_OFS_MODE, 32'h69);
    rd_chk(DTC_OFS_CNT0, 32'h0);
    rd_chk(DTC_OFS_CNT1, 32'h0);
    gated(8'h09, 16'h0000, 20, 16'h0014);
    gated(8'h08, 16'h001e, 3, 16'h0101);
    gated(8'h09, 16'h00ff, 2, 16'h0101);
    // enable first, so the reload overflow itself raises the interrupt
    wr(DTC_OFS_IEN, 32'h1);
    gated(8'h0a, 16'h80fe, 3, 16'h8081);
    chk({30'h0, ovf}, 32'h1);
    rd_chk(DTC_OFS_CTRL, 32'h20);
    rd_chk(DTC_OFS_STS, 32'h1);
    chk({31'h0, irq}, 32'h1);
    vector_ack <= 2'h1;
    @(posedge sys_clk);
    vector_ack <= 2'h0;
    repeat (2) @(posedge sys_clk);
    chk({30'h0, ovf}, 32'h0);
    wr(DTC_OFS_IEN, 32'h0);
    rd_chk(DTC_OFS_STS, 32'h1);
    chk({31'h0, irq}, 32'h0);
    wr(DTC_OFS_IEN, 32'h1);
    wr(DTC_OFS_CLR, 32'h1);
    rd_chk(DTC_OFS_STS, 32'h0);
    chk({31'h0, irq}, 32'h0);
    // gate bit clear: the low gate pin must not hold the count back
    wr(DTC_OFS_MODE, 32'h01);
    wr(DTC_OFS_CNT0, 32'h0);
    wr(DTC_OFS_CTRL, 32'h10);
    repeat (10) @(posedge sys_clk);
    // clock enable low for five edges: those edges must not count
    clk_en <= 1'b0;
    repeat (5) @(posedge sys_clk);
    clk_en <= 1'b1;
    wr(DTC_OFS_CTRL, 32'h0);
    rd_chk(DTC_OFS_CNT0, 32'h000d);
    wr(DTC_OFS_MODE, 32'h55);
    wr(DTC_OFS_CNT0, 32'h0);
    wr(DTC_OFS_CNT1, 32'h0);
    wr(DTC_OFS_CTRL, 32'h50);
    dtc_pin_model_inst.count_edges(0, 5);
    dtc_pin_model_inst.count_edges(1, 3);
    repeat (6) @(posedge sys_clk);
    wr(DTC_OFS_CTRL, 32'h0);
    rd_chk(DTC_OFS_CNT0, 32'h5);
    rd_chk(DTC_OFS_CNT1, 32'h3);
    wr(DTC_OFS_MODE, 32'h0b);
    wr(DTC_OFS_CNT0, 32'h0);
    wr(DTC_OFS_CTRL, 32'h50);
    dtc_pin_model_inst.gate_high(0, 4);
    wr(DTC_OFS_CTRL, 32'h0);
    rd_chk(DTC_OFS_MODE, 32'h0b);
    xfer(1'b0, DTC_OFS_CNT0, 32'h0);
    chk({24'h0, rd_val[7:0]}, 32'h4);
    chk({24'h0, rd_val[15:8]}, 32'h8);
    wr(DTC_OFS_MODE, 32'h30);
    wr(DTC_OFS_CNT1, 32'h1234);
    wr(DTC_OFS_CTRL, 32'h40);
    repeat (20) @(posedge sys_clk);
    rd_chk(DTC_OFS_CNT1, 32'h1234);
    end_sim();
  end
endmodule
`default_nettype wire
